// ---- core/lop_defs.vh ----
`ifndef LOP_DEFS_VH
`define LOP_DEFS_VH

// register byte offsets inside one channel window of 0x20
`define LOP_OFF_KIND      5'h00
`define LOP_OFF_CARRIER   5'h04
`define LOP_OFF_XMIN      5'h08
`define LOP_OFF_XMAX      5'h0C
`define LOP_OFF_YMIN      5'h10
`define LOP_OFF_YMAX      5'h14
`define LOP_OFF_CTRL      5'h18
`define LOP_OFF_STATUS    5'h1C

// signal kinds
`define LOP_KIND_UNUSED   3'h0
`define LOP_KIND_CURRENT  3'h1
`define LOP_KIND_VOLTAGE  3'h2
`define LOP_KIND_PWM      3'h3
`define LOP_KIND_FREQ     3'h4
`define LOP_KIND_ONOFF    3'h5

// clock rate and per-unit compare steps on the 28-bit phase accumulator
`define LOP_CLK_HZ        28'hBEBC200
`define LOP_PCT_STEP      28'h01E8480
`define LOP_ANA_FS        16'h4E20
`define LOP_ANA_STEP      28'h0002710
`define LOP_PCT_MAX       16'h0064

// defaults: carrier and target at high command per kind, then the control range
`define LOP_DEF_CARRIER   16'h61A8
`define LOP_DEF_PWM_HZ    16'h03E8
`define LOP_DEF_DUTY      16'h0032
`define LOP_DEF_CUR_HIGH  16'h4E20
`define LOP_DEF_VOLT_HIGH 16'h2710
`define LOP_DEF_PWM_HIGH  16'h0064
`define LOP_DEF_FREQ_HIGH 16'h03E8
`define LOP_DEF_ONOFF_HI  16'h0001
`define LOP_DEF_XMIN      16'h0000
`define LOP_DEF_XMAX      16'h2710

`endif

// ---- core/lop_lin.v ----
`timescale 1ns/1ps
`default_nettype none

module lop_lin (
   input  wire        clk,       // system clock
   input  wire        rst,       // async reset, high
   input  wire [15:0] x_min,     // control minimum, signed
   input  wire [15:0] x_max,     // control maximum, signed
   input  wire [15:0] y_min,     // target at low command, signed
   input  wire [15:0] y_max,     // target at high command, signed
   input  wire [15:0] ctrl,      // control value, signed
   output reg  [15:0] target_q   // scaled target, signed
);

   localparam ST_LOAD = 2'h0;
   localparam ST_DIV  = 2'h1;
   localparam ST_DONE = 2'h2;

   reg  [1:0]  st_q;
   reg  [5:0]  cnt_q;
   reg  [33:0] quo_q;
   reg  [17:0] rem_q;
   reg  [16:0] den_q;
   reg         neg_q;
   reg  [15:0] base_q;

   // differences widened by one bit so no range overflows
   wire signed [16:0] dx    = $signed({ctrl[15], ctrl}) - $signed({x_min[15], x_min});
   wire signed [16:0] dr    = $signed({x_max[15], x_max}) - $signed({x_min[15], x_min});
   wire signed [16:0] dy    = $signed({y_max[15], y_max}) - $signed({y_min[15], y_min});
   wire signed [33:0] prod  = dx * dy;
   wire        [33:0] mag   = prod[33] ? (~prod + 34'h000000001) : prod;
   wire               below = ($signed(ctrl) <= $signed(x_min)) || (dr <= 17'sh00000);
   wire               above = $signed(ctrl) >= $signed(x_max);
   wire        [17:0] trial = {rem_q[16:0], quo_q[33]} - {1'b0, den_q};
   wire        [17:0] qs    = neg_q ? (18'h00000 - {1'b0, quo_q[16:0]}) : {1'b0, quo_q[16:0]};
   wire        [17:0] res   = {{2{base_q[15]}}, base_q} + qs;

   // restoring divide of (dy*dx)/dr, restarted forever so control changes track
   // a fresh result lands every 36 cycles; a bounded latency beats a wide divider
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         st_q     <= ST_LOAD;
         cnt_q    <= 6'h00;
         quo_q    <= 34'h000000000;
         rem_q    <= 18'h00000;
         den_q    <= 17'h00000;
         neg_q    <= 1'b0;
         base_q   <= 16'h0000;
         target_q <= 16'h0000;
      end
      else
      begin
         case (st_q)
            ST_LOAD:
            begin
               if (below)
                  target_q <= y_min;
               else if (above)
                  target_q <= y_max;
               else
               begin
                  quo_q  <= mag;
                  rem_q  <= 18'h00000;
                  den_q  <= dr[16:0];
                  neg_q  <= prod[33];
                  base_q <= y_min;
                  cnt_q  <= 6'h22;
                  st_q   <= ST_DIV;
               end
            end
            ST_DIV:
            begin
               if (!trial[17])
               begin
                  rem_q <= trial;
                  quo_q <= {quo_q[32:0], 1'b1};
               end
               else
               begin
                  rem_q <= {rem_q[16:0], quo_q[33]};
                  quo_q <= {quo_q[32:0], 1'b0};
               end
               cnt_q <= cnt_q - 6'h01;
               if (cnt_q == 6'h01)
                  st_q <= ST_DONE;
            end
            ST_DONE:
            begin
               target_q <= res[15:0];
               st_q     <= ST_LOAD;
            end
            default:
               st_q <= ST_LOAD;
         endcase
      end
   end

endmodule

`default_nettype wire

// ---- core/lop_top.v ----
`timescale 1ns/1ps
`default_nettype none
`include "lop_defs.vh"

module lop_top (
   input  wire        CLK,        // 200 MHz system clock
   input  wire        SYS_RST,    // async reset, high
   input  wire [7:0]  ADDR,       // register byte address
   input  wire [31:0] WDATA,      // write data
   input  wire        WR,         // write strobe
   input  wire        RD,         // read strobe
   output reg  [31:0] RDATA,      // read data, cycle after RD
   output wire [3:0]  CH_WAVE,    // channel waveform to driver stage
   output wire [3:0]  CH_NEG,     // analog polarity, high for negative
   output wire [63:0] CH_TARGET   // scaled target, 16 bits per channel
);

   // the read path picks one channel by index out of these
   // packed buses instead of keeping a mux per register
   // flat views of every channel's settings for the read mux
   wire [11:0] kind_w;
   wire [63:0] carrier_w;
   wire [63:0] xmin_w;
   wire [63:0] xmax_w;
   wire [63:0] ymin_w;
   wire [63:0] ymax_w;
   wire [63:0] ctrl_w;
   wire [63:0] tgt_w;

   // register map, one 32-byte window per channel:
   //   ADDR[7]    must be low, else the access misses
   //   ADDR[6:5]  channel number
   //   ADDR[4:0]  register offset, word aligned
   // offsets inside a window:
   //   00 signal kind, three bits
   //   04 carrier: hertz, or duty percent in frequency mode
   //   08 control minimum, signed
   //   0C control maximum, signed
   //   10 target at low command, signed
   //   14 target at high command, signed
   //   18 control value, signed
   //   1C status, read only: polarity, wave, kind, target
   // misaligned or out-of-window reads return zero
   // writes to status or to a missed address are dropped
   wire [1:0]  rsel = ADDR[6:5];
   wire        rhit = ~ADDR[7] & (ADDR[1:0] == 2'h0);

   genvar i;
   generate
      // one copy of settings, scaler and timer per channel; nothing
      // is shared, so a change on one channel never reaches another
      for (i = 0; i < 4; i = i + 1)
      begin : g_ch
         reg  [2:0]  kind_q;
         reg  [15:0] carrier_q;
         reg  [15:0] xmin_q;
         reg  [15:0] xmax_q;
         reg  [15:0] ymin_q;
         reg  [15:0] ymax_q;
         reg  [15:0] ctrl_q;
         reg  [27:0] acc_q;
         reg  [27:0] inc_q;
         reg  [27:0] thr_q;
         reg         wave_q;
         reg         neg_q;
         reg  [27:0] inc_d;
         reg  [27:0] thr_d;
         reg  [15:0] mag_d;
         reg  [15:0] def_car;
         reg  [15:0] def_hi;
         wire [15:0] tgt;
         // write select for this channel, and the phase sum with one
         // spare bit so the wrap test cannot overflow
         wire        wsel = WR & ~ADDR[7] & (ADDR[6:5] == i) & (ADDR[1:0] == 2'h0);
         wire [28:0] sum  = {1'b0, acc_q} + {1'b0, inc_q};
         wire        wrap = sum >= {1'b0, `LOP_CLK_HZ};
         wire [27:0] acc_d = wrap ? (sum[27:0] - `LOP_CLK_HZ) : sum[27:0];

         // each channel owns a divider; sharing one would make the
         // four latencies depend on each other
         // the target trails a settings change by up to two divide
         // rounds, about 72 clocks
         // own linear scaler per channel
         lop_lin u_lin (
            .clk      (CLK),
            .rst      (SYS_RST),
            .x_min    (xmin_q),
            .x_max    (xmax_q),
            .y_min    (ymin_q),
            .y_max    (ymax_q),
            .ctrl     (ctrl_q),
            .target_q (tgt)
         );

         // only read on a kind write; unused and undefined kinds park
         // the timer with a zero carrier and a flat zero target range
         // current and voltage share the carrier default and differ
         // only in the high target
         // defaults that a kind write loads into carrier and high target
         always @*
         begin
            def_car = `LOP_DEF_CARRIER;
            def_hi  = 16'h0000;
            case (WDATA[2:0])
               `LOP_KIND_CURRENT: def_hi = `LOP_DEF_CUR_HIGH;
               `LOP_KIND_VOLTAGE: def_hi = `LOP_DEF_VOLT_HIGH;
               `LOP_KIND_PWM:
               begin
                  def_car = `LOP_DEF_PWM_HZ;
                  def_hi  = `LOP_DEF_PWM_HIGH;
               end
               `LOP_KIND_FREQ:
               begin
                  def_car = `LOP_DEF_DUTY;
                  def_hi  = `LOP_DEF_FREQ_HIGH;
               end
               `LOP_KIND_ONOFF:   def_hi = `LOP_DEF_ONOFF_HI;
               default:           def_car = 16'h0000;
            endcase
         end

         // settings; a kind write overwrites carrier and target range
         // the host must write the kind first or lose its carrier and target range
         // control range and value survive a kind write, so a host can
         // retune the kind without rescaling its command
         // all writes apply at the strobe edge; the bus never waits
         always @(posedge CLK or posedge SYS_RST)
         begin
            if (SYS_RST)
            begin
               kind_q    <= `LOP_KIND_VOLTAGE;
               carrier_q <= `LOP_DEF_CARRIER;
               xmin_q    <= `LOP_DEF_XMIN;
               xmax_q    <= `LOP_DEF_XMAX;
               ymin_q    <= 16'h0000;
               ymax_q    <= `LOP_DEF_VOLT_HIGH;
               ctrl_q    <= 16'h0000;
            end
            else if (wsel)
            begin
               case (ADDR[4:0])
                  `LOP_OFF_KIND:
                  begin
                     kind_q    <= WDATA[2:0];
                     carrier_q <= def_car;
                     ymin_q    <= 16'h0000;
                     ymax_q    <= def_hi;
                  end
                  `LOP_OFF_CARRIER: carrier_q <= WDATA[15:0];
                  `LOP_OFF_XMIN:    xmin_q    <= WDATA[15:0];
                  `LOP_OFF_XMAX:    xmax_q    <= WDATA[15:0];
                  `LOP_OFF_YMIN:    ymin_q    <= WDATA[15:0];
                  `LOP_OFF_YMAX:    ymax_q    <= WDATA[15:0];
                  `LOP_OFF_CTRL:    ctrl_q    <= WDATA[15:0];
                  default:          ctrl_q    <= ctrl_q;
               endcase
            end
         end

         // units of the compare level:
         //   analog kinds: full scale 20000 gives an always-high wave,
         //   so the level is magnitude times one period over 20000
         //   pwm: target in percent, level is that share of a period
         //   frequency: target is the step in hertz, carrier the duty
         // the accumulator adds the step every clock and wraps at the
         // clock rate, so a step of N hertz gives N periods a second
         // a negative analog target sets the polarity output and
         // drives its magnitude; pwm clamps negative targets to zero
         // unused and undefined kinds keep the timer idle
         // step and compare level for the timer, from kind and target
         always @*
         begin
            inc_d = 28'h0000000;
            thr_d = 28'h0000000;
            mag_d = tgt[15] ? (16'h0000 - tgt) : tgt;
            case (kind_q)
               `LOP_KIND_CURRENT, `LOP_KIND_VOLTAGE:
               begin
                  if (mag_d > `LOP_ANA_FS)
                     mag_d = `LOP_ANA_FS;
                  inc_d = {12'h000, carrier_q};
                  thr_d = {12'h000, mag_d} * `LOP_ANA_STEP;
               end
               `LOP_KIND_PWM:
               begin
                  mag_d = tgt[15] ? 16'h0000 : tgt;
                  if (mag_d > `LOP_PCT_MAX)
                     mag_d = `LOP_PCT_MAX;
                  inc_d = {12'h000, carrier_q};
                  thr_d = {12'h000, mag_d} * `LOP_PCT_STEP;
               end
               `LOP_KIND_FREQ:
               begin
                  mag_d = (carrier_q > `LOP_PCT_MAX) ? `LOP_PCT_MAX : carrier_q;
                  inc_d = tgt[15] ? 28'h0000000 : {12'h000, tgt};
                  thr_d = {12'h000, mag_d} * `LOP_PCT_STEP;
               end
               default:
               begin
                  inc_d = 28'h0000000;
                  thr_d = 28'h0000000;
               end
            endcase
         end

         // private phase accumulator; wraps mark the period boundary
         // step and level swap only at a wrap or while the timer is idle, so no pulse is ever cut short
         // the wave is high while the phase is below the compare level
         // an idle timer (step zero) reloads on every clock, so a
         // channel leaving the unused kind starts without waiting for
         // a wrap that would never come
         // on/off bypasses the timer and follows the control value
         // limitation: the period jitters by one clock when the step
         // does not divide the clock rate evenly
         always @(posedge CLK or posedge SYS_RST)
         begin
            if (SYS_RST)
            begin
               acc_q  <= 28'h0000000;
               inc_q  <= 28'h0000000;
               thr_q  <= 28'h0000000;
               wave_q <= 1'b0;
               neg_q  <= 1'b0;
            end
            else
            begin
               acc_q <= acc_d;
               if (wrap || (inc_q == 28'h0000000))
               begin
                  inc_q <= inc_d;
                  thr_q <= thr_d;
                  neg_q <= tgt[15] & ((kind_q == `LOP_KIND_CURRENT) |
                                      (kind_q == `LOP_KIND_VOLTAGE));
                  if (inc_d == 28'h0000000)
                     acc_q <= 28'h0000000;
               end
               if (kind_q == `LOP_KIND_ONOFF)
                  wave_q <= (ctrl_q != 16'h0000);
               else if (inc_q == 28'h0000000)
                  wave_q <= 1'b0;
               else
                  wave_q <= acc_d < thr_q;
            end
         end

         // flatten this channel onto the shared buses
         assign CH_WAVE[i]             = wave_q;
         assign CH_NEG[i]              = neg_q;
         assign CH_TARGET[16*i +: 16]  = tgt;
         assign kind_w[3*i +: 3]       = kind_q;
         assign carrier_w[16*i +: 16]  = carrier_q;
         assign xmin_w[16*i +: 16]     = xmin_q;
         assign xmax_w[16*i +: 16]     = xmax_q;
         assign ymin_w[16*i +: 16]     = ymin_q;
         assign ymax_w[16*i +: 16]     = ymax_q;
         assign ctrl_w[16*i +: 16]     = ctrl_q;
         assign tgt_w[16*i +: 16]      = tgt;
      end
   endgenerate

   // reads never stall: the mux is one register deep and the
   // value holds until the next read strobe
   // the status word packs polarity at bit 21, wave at 20,
   // kind at 19:17, a zero at 16 and the target below
   // read data one cycle after the strobe; unmapped reads give zero
   always @(posedge CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
         RDATA <= 32'h00000000;
      else if (RD)
      begin
         if (!rhit)
            RDATA <= 32'h00000000;
         else
         begin
            case (ADDR[4:0])
               `LOP_OFF_KIND:    RDATA <= {29'h00000000, kind_w[3*rsel +: 3]};
               `LOP_OFF_CARRIER: RDATA <= {16'h0000, carrier_w[16*rsel +: 16]};
               `LOP_OFF_XMIN:    RDATA <= {16'h0000, xmin_w[16*rsel +: 16]};
               `LOP_OFF_XMAX:    RDATA <= {16'h0000, xmax_w[16*rsel +: 16]};
               `LOP_OFF_YMIN:    RDATA <= {16'h0000, ymin_w[16*rsel +: 16]};
               `LOP_OFF_YMAX:    RDATA <= {16'h0000, ymax_w[16*rsel +: 16]};
               `LOP_OFF_CTRL:    RDATA <= {16'h0000, ctrl_w[16*rsel +: 16]};
               `LOP_OFF_STATUS:  RDATA <= {10'h000, CH_NEG[rsel], CH_WAVE[rsel],
                                           kind_w[3*rsel +: 3], 1'b0, tgt_w[16*rsel +: 16]};
               default:          RDATA <= 32'h00000000;
            endcase
         end
      end
   end

endmodule

`default_nettype wire

// ---- testbench/lop_drv_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module lop_drv_model (
   input  wire logic             clk,     // system clock
   input  wire logic             rst,     // async reset, high
   input  wire logic [3:0]       wave,    // channel waveforms
   output var  logic [3:0][31:0] period,  // last rise-to-rise span
   output var  logic [3:0][31:0] high     // last high span
);
   logic [3:0]       prev_q;
   logic [3:0][31:0] cnt_q;
   logic [3:0][31:0] hc_q;

   // the stage only sees edges, so periods are taken between rises and high spans from rise to fall
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         prev_q <= 4'h0;
         cnt_q  <= '0;
         hc_q   <= '0;
         period <= '0;
         high   <= '0;
      end
      else
      begin
         prev_q <= wave;
         for (int i = 0; i < 4; i++)
         begin
            cnt_q[i] <= (wave[i] && !prev_q[i]) ? 32'h1 : cnt_q[i] + 32'h1;
            if (wave[i] && !prev_q[i])
               period[i] <= cnt_q[i];
            hc_q[i] <= wave[i] ? hc_q[i] + 32'h1 : 32'h0;
            if (!wave[i] && prev_q[i])
               high[i] <= hc_q[i];
         end
      end
   end
endmodule
`default_nettype wire

// ---- testbench/lop_top_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module lop_asserts (
   input wire logic        CLK,       // clock
   input wire logic        SYS_RST,   // async reset
   input wire logic [7:0]  ADDR,      // address
   input wire logic [31:0] WDATA,     // write data
   input wire logic        WR,        // write strobe
   input wire logic        RD,        // read strobe
   input wire logic [31:0] RDATA,     // read data
   input wire logic [3:0]  CH_WAVE,   // waveforms
   input wire logic [3:0]  CH_NEG,    // polarity
   input wire logic [63:0] CH_TARGET  // targets
);
   localparam logic [15:0] CAR_T [0:7] = '{16'h0, 16'h61A8, 16'h61A8, 16'h3E8, 16'h32, 16'h61A8, 16'h0, 16'h0};
   localparam logic [15:0] HI_T [0:7]  = '{16'h0, 16'h4E20, 16'h2710, 16'h64, 16'h3E8, 16'h1, 16'h0, 16'h0};
   logic [2:0]  kind_q [0:3];
   logic [15:0] ctrl0_q;
   logic [6:0]  quiet0_q;
   wire         mapped = !ADDR[7] && ADDR[1:0] == 2'h0;
   wire         wr0    = WR && mapped && ADDR[6:5] == 2'h0;

   // shadow kinds and channel 0 control; quiet count saturates, never wraps
   always_ff @(posedge CLK or posedge SYS_RST)
      if (SYS_RST)
      begin
         kind_q   <= '{4{3'h2}};
         ctrl0_q  <= 16'h0;
         quiet0_q <= 7'h00;
      end
      else
      begin
         if (WR && mapped && ADDR[4:0] == 5'h0)
            kind_q[ADDR[6:5]] <= WDATA[2:0];
         if (wr0 && ADDR[4:0] == 5'h18)
            ctrl0_q <= WDATA[15:0];
         quiet0_q <= wr0 ? 7'h00 : (quiet0_q == 7'h7F ? quiet0_q : quiet0_q + 7'h01);
      end

   default clocking dc @(posedge CLK);
   endclocking
   default disable iff (SYS_RST);

   AST_UNMAPPED: assert property (RD && ADDR[7] |=> RDATA == 32'h0)
      else $error("unmapped read not zero");
   AST_KIND_READ: assert property (RD && mapped && ADDR[4:0] == 5'h0 |=> RDATA == {29'h0, kind_q[$past(ADDR[6:5])]})
      else $error("kind read mismatch");
   AST_STATUS_KIND: assert property (RD && mapped && ADDR[4:0] == 5'h1C |=> RDATA[19:16] == {kind_q[$past(ADDR[6:5])], 1'b0})
      else $error("status kind mismatch");
   AST_CARRIER_DEF: assert property (WR && mapped && ADDR[4:0] == 5'h0 ##1 !WR
      ##1 RD && ADDR == $past(ADDR, 2) + 8'h4 |=> RDATA == {16'h0, CAR_T[$past(WDATA[2:0], 3)]})
      else $error("carrier not reloaded");
   AST_HIGH_DEF: assert property (WR && mapped && ADDR[4:0] == 5'h0 ##1 !WR
      ##1 RD && ADDR == $past(ADDR, 2) + 8'h14 |=> RDATA == {16'h0, HI_T[$past(WDATA[2:0], 3)]})
      else $error("high target not reloaded");
   AST_ONOFF: assert property (kind_q[0] == 3'h5 && quiet0_q > 7'h02 |-> CH_WAVE[0] == (ctrl0_q != 16'h0))
      else $error("on/off level wrong");
   // the fresh divide round can land up to 71 clocks after the last write
   AST_TARGET_STABLE: assert property (quiet0_q > 7'h48 |=> $stable(CH_TARGET[15:0]))
      else $error("settled target moved");
   AST_RDATA_HOLD: assert property (!RD |=> $stable(RDATA))
      else $error("read data moved without read");

   // main scenarios reached
   cover property (WR && mapped && ADDR[4:0] == 5'h0 && WDATA[2:0] == 3'h3);
   cover property ($rose(CH_WAVE[0]));
   cover property (RD && ADDR[7]);
endmodule

bind lop_top lop_asserts lop_asserts_inst (
   .CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
   .RDATA(RDATA), .CH_WAVE(CH_WAVE), .CH_NEG(CH_NEG), .CH_TARGET(CH_TARGET));
`default_nettype wire

// ---- testbench/lop_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module lop_top_tb;
   localparam logic [15:0] CAR_T [0:7] = '{16'h0, 16'h61A8, 16'h61A8, 16'h3E8, 16'h32, 16'h61A8, 16'h0, 16'h0};
   localparam logic [15:0] HI_T [0:7]  = '{16'h0, 16'h4E20, 16'h2710, 16'h64, 16'h3E8, 16'h1, 16'h0, 16'h0};
   logic             clk = 1'b0;
   logic             sys_rst = 1'b1;
   logic [7:0]       addr = 8'h0;
   logic [31:0]      wdata = 32'h0;
   logic             wr = 1'b0;
   logic             rd = 1'b0;
   wire  [31:0]      rdata;
   wire  [3:0]       ch_wave;
   wire  [3:0]       ch_neg;
   wire  [63:0]      ch_target;
   wire  [3:0][31:0] per;
   wire  [3:0][31:0] hi;
   logic [15:0]      seed = 16'hDC26;
   logic [31:0]      d;
   logic [3:0]       wv;
   logic [63:0]      tg;
   logic [3:0]       ng;
   int               mismatches = 0;
   int               n_tests = 0;
   int               xn, xx, yn, yx, c, e;

   always #2.5 clk = ~clk;

   lop_top lop_top_inst (.CLK(clk), .SYS_RST(sys_rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .CH_WAVE(ch_wave), .CH_NEG(ch_neg), .CH_TARGET(ch_target));
   lop_drv_model lop_drv_model_inst (.clk(clk), .rst(sys_rst), .wave(ch_wave), .period(per), .high(hi));

   // random source and expected scaling
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic int scale(input int xn, xx, yn, yx, c);
      if (c <= xn)
         return yn;
      if (c >= xx)
         return yx;
      return yn + int'((longint'(yx - yn) * (c - xn)) / (xx - xn));
   endfunction

   // bus tasks start on an edge and end on one; a write leaves one idle
   // edge so its strobe is never lowered and raised in one time step
   task automatic bus_wr(input logic [7:0] a, input logic [15:0] v);
      wr <= 1'b1;
      addr <= a;
      wdata <= {16'h0, v};
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic bus_rd(input logic [7:0] a);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
      wv = ch_wave;
      tg = ch_target;
      ng = ch_neg;
      @(posedge clk);
   endtask
   task automatic chk(input logic [31:0] got, lo, hi);
      n_tests++;
      if (^got === 1'bx || got < lo || got > hi)
      begin
         mismatches++;
         $display("FAIL %0t got %0d want %0d..%0d", $time, got, lo, hi);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // cut a hang well beyond the roughly 75k cycles the tests need
   initial
   begin
      repeat (100000) @(posedge clk);
      mismatches++;
      $display("FAIL %0t watchdog", $time);
      give_verdict();
   end

   initial
   begin
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      for (int ch = 0; ch < 4; ch++)
      begin
         bus_rd(8'(ch * 32));
         chk(d, 2, 2);
         bus_rd(8'(ch * 32 + 4));
         chk(d, 32'h61A8, 32'h61A8);
      end
      $display("test defaults done");
      for (int k = 0; k < 8; k++)
      begin
         bus_wr(8'h20, 16'(k));
         bus_rd(8'h24);
         chk(d, CAR_T[k], CAR_T[k]);
         bus_wr(8'h20, 16'(k));
         bus_rd(8'h34);
         chk(d, HI_T[k], HI_T[k]);
         bus_rd(8'h3C);
         chk(d[19:17], k, k);
      end
      bus_wr(8'h80, 16'h1234);
      bus_rd(8'h80);
      chk(d, 0, 0);
      $display("test kinds done");
      for (int i = 0; i < 20; i++)
      begin
         seed = lfsr(seed);
         xn = $signed(seed) / 4;
         seed = lfsr(seed);
         xx = xn + 1 + seed[11:0];
         seed = lfsr(seed);
         yn = $signed(seed);
         seed = lfsr(seed);
         yx = $signed(seed);
         seed = lfsr(seed);
         c = (i == 0) ? xn : (i == 1) ? xx : xn - 200 + int'(seed) % (xx - xn + 400);
         bus_wr(8'h00, 16'h2);
         bus_wr(8'h08, xn[15:0]);
         bus_wr(8'h0C, xx[15:0]);
         bus_wr(8'h10, yn[15:0]);
         bus_wr(8'h14, yx[15:0]);
         bus_wr(8'h18, c[15:0]);
         repeat (80) @(posedge clk);
         e = scale(xn, xx, yn, yx, c);
         bus_wr(8'h38, seed);
         bus_rd(8'h1C);
         chk(d[15:0], e[15:0], e[15:0]);
         chk(tg[15:0], e[15:0], e[15:0]);
      end
      $display("test scaling done");
      bus_wr(8'h10, 16'hF000);
      bus_wr(8'h18, 16'h8000);
      repeat (8200) @(posedge clk);
      bus_rd(8'h1C);
      chk(tg[15:0], 16'hF000, 16'hF000);
      chk(d[21], 1, 1);
      chk(ng[0], 1, 1);
      $display("test polarity done");
      bus_wr(8'h00, 16'h5);
      bus_wr(8'h18, 16'h7);
      repeat (3) @(posedge clk);
      bus_rd(8'h1C);
      chk(wv[0], 1, 1);
      bus_wr(8'h18, 16'h0);
      repeat (3) @(posedge clk);
      bus_rd(8'h1C);
      chk(wv[0], 0, 0);
      $display("test on/off done");
      bus_wr(8'h40, 16'h3);
      bus_wr(8'h44, 16'hC350);
      bus_wr(8'h58, 16'h9C4);
      bus_wr(8'h60, 16'h4);
      bus_wr(8'h74, 16'h4E20);
      bus_wr(8'h78, 16'h2710);
      repeat (35000) @(posedge clk);
      @(negedge clk);
      chk(per[2], 3999, 4001);
      chk(hi[2], 999, 1001);
      chk(per[3], 9999, 10001);
      chk(hi[3], 4999, 5001);
      @(posedge clk);
      bus_wr(8'h44, 16'h9C40);
      repeat (30000) @(posedge clk);
      @(negedge clk);
      chk(per[2], 4999, 5001);
      chk(per[3], 9999, 10001);
      $display("test waveforms done");
      give_verdict();
   end
endmodule
`default_nettype wire
